// ---- design/pmc_pkg.sv ----
/*
 * Package for the power-mode clock controller: register offset, bit
 * positions, reset values, wake delay counts and the state enum.
 * Assumes a single 125 MHz core clock domain.
 */
package pmc_pkg;

	localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;

	localparam int IDLE_BIT = 0;
	localparam int PDOWN_BIT = 1;
	localparam int GF0_BIT = 2;
	localparam int GF1_BIT = 3;
	localparam int SHORT_WAKE_DELAY_SELECT_BIT = 4;
	localparam int RFI_BIT = 5;
	localparam int ARD_BIT = 6;
	localparam int BAUD_DOUBLE_BIT = 7;

	// Wake delay in oscillator periods; one period is one core_clk cycle
	localparam int LONG_WAKE_PERIODS = 1024;
	localparam int SHORT_WAKE_PERIODS = 32;
	localparam logic [10:0] LONG_WAKE_CYCLES = 11'(LONG_WAKE_PERIODS);
	localparam logic [10:0] SHORT_WAKE_CYCLES = 11'(SHORT_WAKE_PERIODS);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_PDOWN,
		ST_WAKE
	} pm_state_e;

	// Special function register write/read port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	// Pin values presented to the pads
	typedef struct packed {
		logic ale;
		logic prog_strobe;
		logic [7:0] port_two;
		logic osc_in_pulldown;
		logic osc_out_pulldown;
		logic osc_current_on;
		logic osc_clock_on;
		logic clk_out_sel;
	} pin_ctl_s;

endpackage

// ---- design/power_mode_clock_control.sv ----
/*
 * Power-mode clock controller: power mode control register, idle and
 * power-down sequencing, wake delay, pin states and clock gating.
 * Assumes the core writes the register at instruction end and that
 * the other SFRs, RAM and the peripherals live outside.
 */
// Overview of operation
// R01: Idle gates CPU clock, peripherals keep running
// R02: Idle bit write enters idle after instruction
// R03: Idle preserves CPU state and memories
// R04: Enabled interrupt clears idle bit, resumes
// R05: Reset ending idle held two machine cycles
// R06: Reset restores registers, leaves RAM untouched
// R07: Power-down bit stops oscillator, keeps contents
// R08: Only power-down bit or detector stop oscillator
// R09: Power-down ports hold latch, strobes fixed
// R10: Port two returns to latch in power-down
// R11: Wake on irq two-nine, reset, detector, clock
// R12: Wake delay 1024 or 32 periods
// R13: Power-down wins over simultaneous idle request
// R14: Register resets to zero, not bit addressable
// R15: Baud double bit doubles serial rate
// R16: Aux RAM disable routes moves externally
// R17: Interference bit stops address strobe toggling
// R18: General flags hold written value
// R19: Power-down pulls oscillator pins low, disabled
// R20: Clock output bit drives clock onto pin
// R21: Software stops EEPROM before power-down
// R22: Wake reset held until oscillator stable
`timescale 1ns/1ps
module power_mode_clock_control
	import pmc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Register port from the core
	input wire sfr_req_s sfr_req,
	input wire logic instr_done,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Wake and entry sources
	input wire logic [7:0] ext_irq_lines_two_to_nine,
	input wire logic [7:0] ext_irq_enable,
	input wire logic irq_accepted,
	input wire logic low_voltage_detector_pd,
	input wire logic low_voltage_detector_wake,
	input wire logic rtc_wake,
	// Pin sources from the bus unit
	input wire logic ale_normal,
	input wire logic prog_store_normal,
	input wire logic ext_fetch,
	input wire logic [7:0] port_two_address,
	input wire logic [7:0] port_two_latch,
	input wire logic clock_output_enable,
	// Clock gating and mode status
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output pin_ctl_s pins,
	output logic baud_double,
	output logic aux_ram_disable,
	output logic idle_active,
	output logic pdown_active
);

	typedef struct packed {
		pm_state_e state;
		logic [7:0] power_mode_control;
		logic [7:0] rdata;
		logic hit;
		logic idle_pend;
		logic pd_pend;
		logic cpu_en;
		logic per_en;
		pin_ctl_s pins;
		logic [2:0] irq_sync1;
		logic [2:0] irq_sync2;
		logic [2:0] irq_sync3;
		logic [7:0] irq_a;
		logic [7:0] irq_b;
		logic [7:0] irq_c;
		logic wake_start;
		logic idle_flag;
		logic pd_flag;
	} pmc_s;

	pmc_s st_q;
	pmc_s st_d;
	logic wd_busy;
	logic wd_done;
	logic irq_wake;
	logic src_wake;
	logic lvd_entry;
	logic [7:0] power_mode_control_wr;

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == POWER_MODE_CONTROL_ADDR);
	endfunction

	wake_delay_counter u_wake (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.start(st_q.wake_start),
		.short_sel(st_q.power_mode_control[SHORT_WAKE_DELAY_SELECT_BIT]),
		.busy(wd_busy),
		.done(wd_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;
		st_d.wake_start = 1'b0;
		// Pins stay asynchronous: agree on second and third stage
		st_d.irq_a = ext_irq_lines_two_to_nine;
		st_d.irq_b = st_q.irq_a;
		st_d.irq_c = st_q.irq_b;
		st_d.irq_sync1 = {low_voltage_detector_pd, low_voltage_detector_wake, rtc_wake};
		st_d.irq_sync2 = st_q.irq_sync1;
		st_d.irq_sync3 = st_q.irq_sync2;
		irq_wake = |(st_q.irq_b & st_q.irq_c & ext_irq_enable); // R11
		src_wake = |(st_q.irq_sync2[1:0] & st_q.irq_sync3[1:0]); // R11
		lvd_entry = st_q.irq_sync2[2] && st_q.irq_sync3[2]; // R08
		power_mode_control_wr = sfr_req.wdata;
		st_d.hit = sfr_req.rd && addr_hit(sfr_req.addr);
		st_d.rdata = st_d.hit ? st_q.power_mode_control : 8'h00;
		// Whole-byte write only; no bit addressing
		if (sfr_req.wr && addr_hit(sfr_req.addr)) begin // R14
			st_d.power_mode_control = power_mode_control_wr; // R15 R16 R17 R18
			if (power_mode_control_wr[PDOWN_BIT]) begin
				st_d.pd_pend = 1'b1; // R07
				st_d.idle_pend = 1'b0; // R13
				st_d.power_mode_control[IDLE_BIT] = 1'b0; // R13
			end else if (power_mode_control_wr[IDLE_BIT]) begin
				st_d.idle_pend = 1'b1; // R02
			end
		end
		case (st_q.state)
			ST_RUN: begin
				if (instr_done && (st_d.pd_pend || lvd_entry)) begin // R08
					st_d.state = ST_PDOWN;
					st_d.pd_pend = 1'b0;
					st_d.idle_pend = 1'b0;
				end else if (instr_done && st_d.idle_pend) begin
					st_d.state = ST_IDLE; // R02
					st_d.idle_pend = 1'b0;
				end
			end
			ST_IDLE: begin
				// CPU state frozen by gated clock, peripherals live
				if (irq_accepted) begin // R04
					st_d.power_mode_control[IDLE_BIT] = 1'b0;
					st_d.state = ST_RUN;
				end
			end
			ST_PDOWN: begin
				if (irq_wake || src_wake) begin // R11
					st_d.state = ST_WAKE;
					st_d.wake_start = 1'b1; // R12
				end
			end
			ST_WAKE: begin
				if (wd_done) begin
					st_d.power_mode_control[PDOWN_BIT] = 1'b0;
					st_d.state = ST_RUN;
				end
			end
			default: st_d.state = ST_RUN;
		endcase
		// Clock gating per the state being entered
		st_d.cpu_en = (st_d.state == ST_RUN); // R01 R03
		st_d.per_en = (st_d.state == ST_RUN) || (st_d.state == ST_IDLE); // R01
		st_d.idle_flag = (st_d.state == ST_IDLE);
		st_d.pd_flag = (st_d.state == ST_PDOWN);
		// Pin states
		if (st_d.state == ST_PDOWN || st_d.state == ST_WAKE) begin
			st_d.pins.ale = 1'b0; // R09
			st_d.pins.prog_strobe = 1'b1; // R09
			st_d.pins.port_two = port_two_latch; // R10
			st_d.pins.osc_in_pulldown = (st_d.state == ST_PDOWN); // R19
			st_d.pins.osc_out_pulldown = (st_d.state == ST_PDOWN); // R19
			st_d.pins.osc_current_on = (st_d.state != ST_PDOWN); // R19
			st_d.pins.osc_clock_on = (st_d.state != ST_PDOWN); // R19
			st_d.pins.clk_out_sel = 1'b0;
		end else begin
			st_d.pins.ale = (st_d.state == ST_IDLE) ? 1'b1 :
				(st_d.power_mode_control[RFI_BIT] ? 1'b1 : ale_normal); // R17
			st_d.pins.prog_strobe = (st_d.state == ST_IDLE) ? 1'b1 : prog_store_normal;
			st_d.pins.port_two = ext_fetch ? port_two_address : port_two_latch;
			st_d.pins.osc_in_pulldown = 1'b0;
			st_d.pins.osc_out_pulldown = 1'b0;
			st_d.pins.osc_current_on = 1'b1;
			st_d.pins.osc_clock_on = 1'b1;
			st_d.pins.clk_out_sel = clock_output_enable; // R20
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0; // R06 R14
			st_q.state <= ST_RUN;
			st_q.power_mode_control <= POWER_MODE_CONTROL_RESET;
			st_q.cpu_en <= 1'b1;
			st_q.per_en <= 1'b1;
			st_q.pins.ale <= 1'b1;
			st_q.pins.prog_strobe <= 1'b1;
			st_q.pins.osc_current_on <= 1'b1;
			st_q.pins.osc_clock_on <= 1'b1;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign sfr_rdata = st_q.rdata;
	assign sfr_hit = st_q.hit;
	assign cpu_clk_en = st_q.cpu_en;
	assign periph_clk_en = st_q.per_en;
	assign pins = st_q.pins;
	assign baud_double = st_q.power_mode_control[BAUD_DOUBLE_BIT];
	assign aux_ram_disable = st_q.power_mode_control[ARD_BIT];
	assign idle_active = st_q.idle_flag;
	assign pdown_active = st_q.pd_flag;

	////////////////////////////////////////////////////////////////////////
	// Checks

	idle_gates_cpu_a: assert property (@(posedge core_clk) disable iff (rst) // R01
		st_q.state == ST_IDLE |-> !cpu_clk_en && periph_clk_en)
		else $error("idle mode clock gating wrong");

	pd_osc_off_a: assert property (@(posedge core_clk) disable iff (rst) // R19
		st_q.state == ST_PDOWN |-> !pins.osc_clock_on && !pins.osc_current_on)
		else $error("oscillator not off in power-down");

	pd_strobes_a: assert property (@(posedge core_clk) disable iff (rst) // R09
		st_q.state == ST_PDOWN |-> !pins.ale && pins.prog_strobe)
		else $error("strobes wrong in power-down");

	pd_wins_a: assert property (@(posedge core_clk) disable iff (rst) // R13
		clk_en && sfr_req.wr && addr_hit(sfr_req.addr) && sfr_req.wdata[1]
		|=> !st_q.power_mode_control[IDLE_BIT] && !st_q.idle_pend)
		else $error("idle taken with power-down");

	flags_hold_a: assert property (@(posedge core_clk) disable iff (rst) // R18
		clk_en && sfr_req.wr && addr_hit(sfr_req.addr)
		|=> st_q.power_mode_control[3:2] == $past(sfr_req.wdata[3:2]))
		else $error("general flags not stored");

	idle_exit_a: assert property (@(posedge core_clk) disable iff (rst) // R04
		clk_en && st_q.state == ST_IDLE && irq_accepted
		|=> st_q.state == ST_RUN && !st_q.power_mode_control[IDLE_BIT])
		else $error("interrupt did not end idle");

	short_wake_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en) // R12
		st_q.wake_start && st_q.power_mode_control[SHORT_WAKE_DELAY_SELECT_BIT] |-> ##33 wd_done)
		else $error("short wake delay wrong");

	wake_clock_off_a: assert property (@(posedge core_clk) disable iff (rst) // R12
		st_q.state == ST_WAKE |-> !cpu_clk_en && (st_q.wake_start || wd_busy || wd_done))
		else $error("cpu clock on during wake delay");

	baud_follow_a: assert property (@(posedge core_clk) disable iff (rst) // R15 R16
		clk_en && sfr_req.wr && addr_hit(sfr_req.addr)
		|=> baud_double == $past(sfr_req.wdata[BAUD_DOUBLE_BIT])
		&& aux_ram_disable == $past(sfr_req.wdata[ARD_BIT]))
		else $error("mode outputs do not follow register");

	idle_entry_a: assert property (@(posedge core_clk) disable iff (rst) // R02
		clk_en && st_q.state == ST_RUN && instr_done && sfr_req.wr && addr_hit(sfr_req.addr)
		&& sfr_req.wdata[IDLE_BIT] |=> !cpu_clk_en && (idle_active || pdown_active))
		else $error("idle request did not stop cpu clock");

	pd_entry_a: assert property (@(posedge core_clk) disable iff (rst) // R07
		clk_en && st_q.state == ST_RUN && instr_done && sfr_req.wr && addr_hit(sfr_req.addr)
		&& sfr_req.wdata[PDOWN_BIT] |=> pdown_active && st_q.power_mode_control[PDOWN_BIT])
		else $error("power-down request not taken");

	pd_entry_point_a: assert property (@(posedge core_clk) disable iff (rst) // R08
		$rose(pdown_active) |-> $past(instr_done) && $past(st_q.state) == ST_RUN)
		else $error("power-down entered outside an instruction end");

	port_two_pd_a: assert property (@(posedge core_clk) disable iff (rst) // R10
		st_q.state == ST_PDOWN && $past(clk_en) |-> pins.port_two == $past(port_two_latch))
		else $error("port two not from latch in power-down");

	idle_hold_a: assert property (@(posedge core_clk) disable iff (rst) // R03
		clk_en && st_q.state == ST_IDLE && !irq_accepted |=> idle_active && !cpu_clk_en)
		else $error("idle left without interrupt");

	rfi_ale_a: assert property (@(posedge core_clk) disable iff (rst) // R17
		st_q.state == ST_RUN && st_q.power_mode_control[RFI_BIT] |-> pins.ale)
		else $error("address strobe toggles with reduction set");

	clk_out_a: assert property (@(posedge core_clk) disable iff (rst) // R20
		st_q.state == ST_RUN && !$past(rst) && $past(clk_en) && $past(clock_output_enable)
		|-> pins.clk_out_sel)
		else $error("clock output select not driven");

	read_hit_a: assert property (@(posedge core_clk) disable iff (rst) // R14
		clk_en && sfr_req.rd && addr_hit(sfr_req.addr)
		|=> sfr_hit && sfr_rdata == $past(st_q.power_mode_control))
		else $error("register read not answered");

	read_miss_a: assert property (@(posedge core_clk) disable iff (rst) // R14
		clk_en && !(sfr_req.rd && addr_hit(sfr_req.addr)) |=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("read data outside a register read");

	wake_done_a: assert property (@(posedge core_clk) disable iff (rst) // R12
		clk_en && st_q.state == ST_WAKE && wd_done
		|=> cpu_clk_en && !pdown_active && !st_q.power_mode_control[PDOWN_BIT])
		else $error("run not resumed after wake delay");

endmodule

// ---- design/wake_delay_counter.sv ----
/*
 * Wake-up stabilisation counter: counts the chosen number of cycles
 * after start and then raises done for one cycle.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/1ps
module wake_delay_counter
	import pmc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Control
	input wire logic start,
	input wire logic short_sel,
	// Status
	output logic busy,
	output logic done
);

	typedef struct packed {
		logic [10:0] cnt;
		logic busy;
		logic done;
	} wdc_s;

	wdc_s st_q;
	wdc_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		if (start) begin
			st_d.busy = 1'b1;
			st_d.cnt = short_sel ? SHORT_WAKE_CYCLES - 11'h001 : LONG_WAKE_CYCLES - 11'h001; // R12
		end else if (st_q.busy) begin
			if (st_q.cnt == 11'h000) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - 11'h001;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign busy = st_q.busy;
	assign done = st_q.done;

endmodule

// ---- verif/irq_accept_model.sv ----
/* Interrupt logic model on the core side of the controller.
   Assumes the bench drives request lines off the clock edge. */
`timescale 1ns/1ps
module irq_accept_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Requests and mode
	input wire logic [7:0] lines,
	input wire logic [7:0] enable,
	input wire logic idle_active,
	// Acceptance
	output logic irq_accepted
);
	// Pulses on alternate cycles while idle_active is high, enabled lines only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_accepted <= 1'b0;
		end else begin
			irq_accepted <= idle_active && |(lines & enable) && !irq_accepted;
		end
	end
endmodule

// ---- verif/tb.sv ----
/* Self-checking bench for the power-mode clock controller.
   Assumes one oscillator period is one core_clk cycle. */
`timescale 1ns/1ps
module tb;
	import pmc_pkg::*;
	logic core_clk = 0, rst = 1, clk_en = 1, instr_done = 0, irq_accepted;
	sfr_req_s sfr_req = '0;
	logic [7:0] sfr_rdata, lines = 0, en = 0, p2a = 0, p2l = 0, v;
	logic sfr_hit, lvd_pd = 0, lvd_wake = 0, rtc = 0, ale_n = 0, ps_n = 1;
	logic ext_fetch = 0, coe = 0, cpu_clk_en, periph_clk_en, baud_double;
	logic aux_ram_disable, idle_active, pdown_active, a;
	pin_ctl_s pins;
	logic [31:0] seed = 32'h0000_798A;
	logic [7:0] exp_q[$];
	int fails = 0, num_checks = 0, cycles = 0, n, w;

	always #4 core_clk = ~core_clk;

	power_mode_clock_control i_power_mode_clock_control (.core_clk(core_clk), .rst(rst),
		.clk_en(clk_en), .sfr_req(sfr_req), .instr_done(instr_done), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .ext_irq_lines_two_to_nine(lines), .ext_irq_enable(en),
		.irq_accepted(irq_accepted), .low_voltage_detector_pd(lvd_pd),
		.low_voltage_detector_wake(lvd_wake), .rtc_wake(rtc), .ale_normal(ale_n),
		.prog_store_normal(ps_n), .ext_fetch(ext_fetch), .port_two_address(p2a),
		.port_two_latch(p2l), .clock_output_enable(coe), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .pins(pins), .baud_double(baud_double),
		.aux_ram_disable(aux_ram_disable), .idle_active(idle_active),
		.pdown_active(pdown_active));
	irq_accept_model i_irq_accept_model (.core_clk(core_clk), .rst(rst), .lines(lines),
		.enable(en), .idle_active(idle_active), .irq_accepted(irq_accepted));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] d);
		sfr_req = '{wr: 1'b1, rd: 1'b0, addr: POWER_MODE_CONTROL_ADDR, wdata: d};
		instr_done = 1;
		@(negedge core_clk);
		sfr_req = '0;
		instr_done = 0;
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		sfr_req = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
		if (ad == POWER_MODE_CONTROL_ADDR) begin
			exp_q.push_back(e);
		end
		@(negedge core_clk);
		sfr_req = '0;
		if (ad != POWER_MODE_CONTROL_ADDR) begin
			check(16'({sfr_hit, sfr_rdata}), 16'h0000);
		end
		@(negedge core_clk);
	endtask
	task automatic wait_run();
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 1200) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Read-data scoreboard and background bus-unit traffic
	always @(negedge core_clk) begin
		if (sfr_hit === 1'b1) begin
			check(16'(exp_q.size() != 0), 16'h0001);
			if (exp_q.size() != 0) begin
				check(16'(sfr_rdata), 16'(exp_q.pop_front()));
			end
		end
		ale_n <= rnd() & 1;
		ps_n <= rnd() & 1;
		p2a <= 8'(rnd());
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 12000) begin
			fails++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge core_clk);
		rst = 0;
		rd(POWER_MODE_CONTROL_ADDR, POWER_MODE_CONTROL_RESET);
		rd(8'h88, 8'h00);
		for (int i = 0; i < 2; i++) begin
			v = (8'(rnd()) & 8'hDC) | (i ? 8'h20 : 8'h00);
			wr(v);
			rd(POWER_MODE_CONTROL_ADDR, v);
			check(16'({baud_double, aux_ram_disable}), 16'(v[7:6]));
			a = pins.ale;
			n = 0;
			repeat (16) begin
				@(negedge core_clk);
				n += (pins.ale !== a);
			end
			check(16'(n != 0), 16'(i == 0));
		end
		coe = 1;
		repeat (2) @(negedge core_clk);
		check(16'(pins.clk_out_sel), 16'h0001);
		coe = 0;
		wr(8'h0D);
		check(16'({cpu_clk_en, periph_clk_en, idle_active, pins.clk_out_sel}), 16'h0006);
		rd(POWER_MODE_CONTROL_ADDR, 8'h0D);
		clk_en = 0;
		lines = 8'h01 << (rnd() % 8);
		en = lines;
		repeat (8) @(negedge core_clk);
		check(16'({idle_active, cpu_clk_en}), 16'h0002);
		clk_en = 1;
		wait_run();
		check(16'(n < 12), 16'h0001);
		rd(POWER_MODE_CONTROL_ADDR, 8'h0C);
		lines = 0;
		wr(8'h0D);
		rst = 1;
		repeat (12) @(negedge core_clk);
		rst = 0;
		rd(POWER_MODE_CONTROL_ADDR, 8'h00);
		// Source 0,1 external line, 2 clock tick, 3 detector (entry too)
		for (int k = 0; k < 4; k++) begin
			w = k ? SHORT_WAKE_PERIODS : LONG_WAKE_PERIODS;
			v = k ? 8'h1B : 8'h0B;
			p2l = 8'(rnd());
			ext_fetch = 1;
			lvd_pd = (k == 3);
			repeat (4) @(negedge core_clk);
			wr((k == 3) ? 8'h18 : v);
			lvd_pd = 0;
			check(16'({pdown_active, idle_active, cpu_clk_en}), 16'h0004);
			check(16'({pins.ale, pins.prog_strobe, pins.port_two, pins.osc_in_pulldown,
				pins.osc_out_pulldown, pins.osc_current_on, pins.osc_clock_on}),
				16'({2'b01, p2l, 4'b1100}));
			lines = (k < 2) ? 8'h80 : 8'h00;
			en = (k == 1) ? 8'h00 : 8'hFF;
			if (k == 1) begin
				repeat (40) @(negedge core_clk);
				check(16'(pdown_active), 16'h0001);
				en = 8'hFF;
			end
			rtc = (k == 2);
			lvd_wake = (k == 3);
			wait_run();
			check(16'(n >= w && n <= w + 8), 16'h0001);
			{lines, rtc, lvd_wake, ext_fetch} = '0;
			rd(POWER_MODE_CONTROL_ADDR, v & 8'hF8);
		end
		repeat (4) @(negedge core_clk);
		check(16'(exp_q.size()), 16'h0000);
		final_report();
	end
endmodule
